// ---- src/chained_flags_and_call_stack.sv ----
/*
 * carry and zero flag unit for chained multi-byte arithmetic, compare and
 * test, plus the subroutine return stack with automatic internal reset.
 * assumes the sequencer presents an operation for one cycle at the start of
 * each two-cycle instruction slot; all inputs are on the processor clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "flags_stack_regs.svh"
module chained_flags_and_call_stack
	import flags_stack_pkg::*;
#(
	parameter int DW = `DATA_WIDTH,
	parameter int AW = `ADDR_WIDTH,
	parameter int DEPTH = `STACK_DEPTH
)
(
	// clock and reset
	input wire logic I_CLK_SYS,
	input wire logic I_RESET_N,
	// alu request
	input wire logic i_op_valid,
	input wire alu_op_e i_alu_op,
	input wire logic [DW-1:0] i_destination_register,
	input wire logic [DW-1:0] i_operand,
	// stack request
	input wire stack_op_e i_stack_op,
	input wire logic [AW-1:0] i_return_addr,
	// results
	output logic [DW-1:0] o_result,
	output logic o_write_result,
	output logic o_carry,
	output logic o_zero,
	output logic o_done,
	output logic [AW-1:0] o_return_addr,
	output logic [$clog2(DEPTH+1)-1:0] o_stack_depth,
	output logic o_internal_reset
);
	localparam int SW = $clog2(DEPTH+1);
	localparam int HW = $clog2(`RESET_HOLD+1);
	// refused at elaboration rather than left to misbehave in simulation
	if (DW < 1 || AW < 1 || DEPTH < 1)
	begin
		$error("widths and stack depth must be positive");
	end

	// =====================================================
	// instruction slot: accept only on phase 0
	logic phase;
	logic busy;
	logic take;
	logic [HW-1:0] hold;
	logic hold_active;
	assign hold_active = (hold != '0);
	assign take = i_op_valid && !phase && !hold_active;
	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
			phase <= 1'b0;
		else if (hold_active)
			phase <= 1'b0;
		else if (take)
			phase <= 1'b1;
		else
			phase <= 1'b0;
	end
	assign busy = phase;

	// =====================================================
	// return stack
	logic stk_fault;
	logic [AW-1:0] top_addr;
	logic [SW-1:0] depth;
	return_stack #(
		.DEPTH(DEPTH),
		.AW(AW)
	) u_stack (
		.clk(I_CLK_SYS),
		.rst_n(I_RESET_N),
		.sync_clear(hold_active),
		.push(take && i_stack_op == STK_CALL),
		.pop(take && i_stack_op == STK_RETURN),
		.push_addr(i_return_addr),
		.top_addr(top_addr),
		.depth(depth),
		.fault(stk_fault)
	);

	// internal reset held a few cycles after a stack fault
	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
			hold <= '0;
		else if (stk_fault)
			hold <= HW'(`RESET_HOLD);
		else if (hold_active)
			hold <= hold - HW'(1);
	end
	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
			o_internal_reset <= 1'b0;
		else
			o_internal_reset <= stk_fault || (hold > HW'(1));
	end
	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			o_return_addr <= '0;
			o_stack_depth <= '0;
		end
		else
		begin
			o_return_addr <= top_addr;
			o_stack_depth <= depth;
		end
	end

	// =====================================================
	// flag computation
	logic [DW:0] sum;
	logic [DW-1:0] land;
	logic parity;
	logic next_carry;
	logic next_zero;
	logic writes;
	always_comb
	begin
		sum = '0;
		land = i_destination_register & i_operand;
		parity = ^land;
		next_carry = o_carry;
		next_zero = o_zero;
		writes = 1'b0;
		case (i_alu_op)
			OP_ADD:
			begin
				sum = {1'b0, i_destination_register} + {1'b0, i_operand};
				next_carry = sum[DW];
				next_zero = (sum[DW-1:0] == '0);
				writes = 1'b1;
			end
			OP_ADD_WITH_CARRY:
			begin
				sum = {1'b0, i_destination_register} + {1'b0, i_operand}
					+ {{DW{1'b0}}, o_carry};
				next_carry = sum[DW];
				next_zero = (sum[DW-1:0] == '0) && o_zero;
				writes = 1'b1;
			end
			OP_SUB, OP_COMPARE:
			begin
				sum = {1'b0, i_destination_register} - {1'b0, i_operand};
				next_carry = sum[DW];
				next_zero = (sum[DW-1:0] == '0);
				writes = (i_alu_op == OP_SUB);
			end
			OP_SUBTRACT_WITH_BORROW, OP_CHAINED_COMPARE:
			begin
				sum = {1'b0, i_destination_register} - {1'b0, i_operand}
					- {{DW{1'b0}}, o_carry};
				next_carry = sum[DW];
				next_zero = (sum[DW-1:0] == '0) && o_zero;
				writes = (i_alu_op == OP_SUBTRACT_WITH_BORROW);
			end
			OP_TEST:
			begin
				next_carry = parity;
				next_zero = (land == '0);
			end
			OP_CHAINED_BIT_TEST:
			begin
				next_carry = parity ^ o_carry;
				next_zero = (land == '0) && o_zero;
			end
			default:
			begin
				writes = 1'b0;
			end
		endcase
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			o_carry <= 1'b0;
			o_zero <= 1'b0;
		end
		else if (hold_active || stk_fault)
		begin
			o_carry <= 1'b0;
			o_zero <= 1'b0;
		end
		else if (take)
		begin
			o_carry <= next_carry;
			o_zero <= next_zero;
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			o_result <= '0;
			o_write_result <= 1'b0;
		end
		else
		begin
			o_write_result <= take && writes && !stk_fault;
			if (take)
				o_result <= sum[DW-1:0];
		end
	end

	// done one cycle after busy, two cycles after take: two-cycle slot
	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
			o_done <= 1'b0;
		else
			o_done <= busy && !hold_active;
	end

	// =====================================================
	// checks
	AST_DEPTH_LIMIT: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
		depth <= SW'(DEPTH))
		else $error("stack depth above limit");
	AST_OVERFLOW_RESET: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
		take && i_stack_op == STK_CALL && depth == SW'(DEPTH) |=> o_internal_reset && depth == '0)
		else $error("overflow did not reset");
	AST_UNDERFLOW_RESET: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
		take && i_stack_op == STK_RETURN && depth == '0 |=> o_internal_reset)
		else $error("underflow did not reset");
	AST_SUB_BORROW: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
		take && !stk_fault && i_alu_op == OP_SUB |=>
		o_carry == ($past(i_destination_register) < $past(i_operand)))
		else $error("subtract carry wrong");
	AST_SUBTRACT_WITH_BORROW_VALUE: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
		take && !stk_fault && i_alu_op == OP_SUBTRACT_WITH_BORROW |=>
		o_result == DW'($past(i_destination_register) - $past(i_operand) - $past(o_carry)))
		else $error("chained subtract value wrong");
	AST_CHAIN_ZERO: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
		take && !stk_fault && i_alu_op == OP_SUBTRACT_WITH_BORROW && !o_zero |=> !o_zero)
		else $error("chained zero set without prior zero");
	AST_WRAP_CARRY: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
		take && !stk_fault && i_alu_op == OP_SUBTRACT_WITH_BORROW && o_carry
		&& i_destination_register == '0 && i_operand == '0 |=> o_carry && o_result == '1)
		else $error("wrap did not set carry");
	AST_ADD_WITH_CARRY_ZERO: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
		take && !stk_fault && i_alu_op == OP_ADD_WITH_CARRY && !o_zero |=> !o_zero)
		else $error("chained add zero wrong");
	AST_CMPCY_FLAGS: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
		take && !stk_fault && i_alu_op == OP_CHAINED_COMPARE |=>
		o_zero == ($past(o_zero) && $past(i_destination_register) == $past(i_operand)))
		else $error("chained compare zero wrong");
	AST_TWO_CYCLES: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
		take && !stk_fault |=> busy ##1 (o_done && !busy))
		else $error("instruction not two cycles");
	AST_PLAIN_ZERO: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N)
		take && !stk_fault && i_alu_op == OP_ADD |=>
		o_zero == (DW'($past(i_destination_register) + $past(i_operand)) == '0))
		else $error("plain add zero wrong");
endmodule
`default_nettype wire

// ---- src/flags_stack_regs.svh ----
/*
 * constants for the chained flag and call stack block.
 * assumes inclusion by bare name from the design files.
 */
`ifndef FLAGS_STACK_REGS_SVH
`define FLAGS_STACK_REGS_SVH
`define STACK_DEPTH 30
`define ADDR_WIDTH 12
`define DATA_WIDTH 8
`define INSTR_CYCLES 2
`define RESET_HOLD 4
`endif

// ---- src/flags_stack_pkg.sv ----
/*
 * types for the chained flag and call stack block.
 * assumes nothing of its surroundings.
 */
package flags_stack_pkg;
	typedef enum logic [3:0]
	{
		OP_NONE,
		OP_ADD,
		OP_ADD_WITH_CARRY,
		OP_SUB,
		OP_SUBTRACT_WITH_BORROW,
		OP_COMPARE,
		OP_CHAINED_COMPARE,
		OP_TEST,
		OP_CHAINED_BIT_TEST
	} alu_op_e;
	typedef enum logic [1:0]
	{
		STK_NONE,
		STK_CALL,
		STK_RETURN
	} stack_op_e;
endpackage

// ---- src/return_stack.sv ----
/*
 * return address stack with nesting depth and fault detection.
 * assumes push and pop are single-cycle strobes from the sequencer.
 */
`timescale 1ns/1ps
`default_nettype none
`include "flags_stack_regs.svh"
module return_stack #(
	parameter int DEPTH = `STACK_DEPTH,
	parameter int AW = `ADDR_WIDTH
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sync_clear,
	// requests
	input wire logic push,
	input wire logic pop,
	input wire logic [AW-1:0] push_addr,
	// results
	output logic [AW-1:0] top_addr,
	output logic [$clog2(DEPTH+1)-1:0] depth,
	output logic fault
);
	localparam int DW = $clog2(DEPTH+1);
	logic [AW-1:0] mem [DEPTH];
	// refused at elaboration: an empty stack could never hold a return address
	if (DEPTH < 1 || AW < 1)
	begin
		$error("stack depth and address width must be at least one");
	end
	// =====================================================
	// depth and fault
	assign fault = (push && depth == DW'(DEPTH)) || (pop && depth == '0);
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			depth <= '0;
		else if (sync_clear || fault)
			depth <= '0;
		else if (push)
			depth <= depth + DW'(1);
		else if (pop)
			depth <= depth - DW'(1);
	end
	// =====================================================
	// storage; no reset needed, depth guards every read
	always_ff @(posedge clk)
	begin
		if (push && !fault && !sync_clear)
			mem[depth[DW-1:0]] <= push_addr;
	end
	assign top_addr = (depth == '0) ? '0 : mem[depth - DW'(1)];
endmodule
`default_nettype wire

// ---- tb/seq_model.sv ----
/*
 * sequencer model: one request per issue call, which spans three clock cycles, one more than the two-cycle instruction slot.
 * assumes the block samples its inputs on the rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module seq_model
	import flags_stack_pkg::*;
(
	// clock
	input wire logic clk,
	// requests
	output logic op_valid,
	output alu_op_e alu_op,
	output logic [7:0] dst,
	output logic [7:0] opd,
	output stack_op_e stk,
	output logic [11:0] addr
);
	// ======================================
	// request driver
	initial
	begin
		op_valid = 1'b0;
		alu_op = OP_NONE;
		dst = 8'h00;
		opd = 8'h00;
		stk = STK_NONE;
		addr = 12'h000;
	end
	// held over the take edge only; released data is inverted, not kept
	task automatic issue(input alu_op_e op, input logic [7:0] d, input logic [7:0] o,
		input stack_op_e s, input logic [11:0] a);
		@(posedge clk);
		#1;
		op_valid = 1'b1;
		alu_op = op;
		dst = d;
		opd = o;
		stk = s;
		addr = a;
		@(posedge clk);
		#1;
		op_valid = 1'b0;
		alu_op = OP_NONE;
		stk = STK_NONE;
		dst = ~d;
		opd = ~o;
		addr = ~a;
		@(posedge clk);
		#1;
	endtask
endmodule
`default_nettype wire

// ---- tb/chained_flags_and_call_stack_tb.sv ----
/*
 * self-checking bench for the chained flag and call stack block.
 * assumes the sequencer model drives every request input.
 */
`timescale 1ns/1ps
`default_nettype none
module chained_flags_and_call_stack_tb
	import flags_stack_pkg::*;
;
	// ======================================
	// clock, reset and wiring
	logic I_CLK_SYS = 1'b0;
	logic I_RESET_N = 1'b0;
	logic op_valid, o_write_result, o_carry, o_zero, o_done, o_internal_reset;
	alu_op_e alu_op;
	stack_op_e stk;
	logic [7:0] dst, opd, o_result;
	logic [11:0] addr, o_return_addr;
	logic [4:0] o_stack_depth;
	int bad_count = 0;
	int num_checks = 0;
	int cycles = 0;
	always #5 I_CLK_SYS = ~I_CLK_SYS;
	seq_model i_seq(.clk(I_CLK_SYS), .op_valid(op_valid), .alu_op(alu_op), .dst(dst),
		.opd(opd), .stk(stk), .addr(addr));
	chained_flags_and_call_stack i_dut(.I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N),
		.i_op_valid(op_valid), .i_alu_op(alu_op), .i_destination_register(dst),
		.i_operand(opd), .i_stack_op(stk), .i_return_addr(addr), .o_result(o_result),
		.o_write_result(o_write_result), .o_carry(o_carry), .o_zero(o_zero),
		.o_done(o_done), .o_return_addr(o_return_addr), .o_stack_depth(o_stack_depth),
		.o_internal_reset(o_internal_reset));
	// ======================================
	// helpers
	task automatic close_out;
		if (bad_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
		num_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	// compare and test leave the register alone, so their result is not judged
	task automatic alu(input alu_op_e op, input logic [7:0] d, input logic [7:0] o,
		input logic [7:0] r, input logic c, input logic z);
		i_seq.issue(op, d, o, STK_NONE, 12'h000);
		if (op inside {OP_ADD, OP_ADD_WITH_CARRY, OP_SUB, OP_SUBTRACT_WITH_BORROW})
			chk("result", {4'h0, r}, {4'h0, o_result});
		chk("carry", {11'h000, c}, {11'h000, o_carry});
		chk("zero", {11'h000, z}, {11'h000, o_zero});
	endtask
	task automatic stack_op(input stack_op_e s, input logic [11:0] a);
		i_seq.issue(OP_NONE, 8'h00, 8'h00, s, a);
		@(posedge I_CLK_SYS);
		#1;
	endtask
	// ======================================
	// scenarios
	task automatic t_sub;
		alu(OP_SUB, 8'h00, 8'h01, 8'hff, 1'b1, 1'b0);
		alu(OP_SUBTRACT_WITH_BORROW, 8'h01, 8'h00, 8'h00, 1'b0, 1'b0);
		alu(OP_SUB, 8'h00, 8'h01, 8'hff, 1'b1, 1'b0);
		alu(OP_SUBTRACT_WITH_BORROW, 8'h00, 8'h00, 8'hff, 1'b1, 1'b0);
		alu(OP_SUB, 8'h01, 8'h01, 8'h00, 1'b0, 1'b1);
		alu(OP_SUBTRACT_WITH_BORROW, 8'h05, 8'h05, 8'h00, 1'b0, 1'b1);
		alu(OP_SUB, 8'h05, 8'h01, 8'h04, 1'b0, 1'b0);
		alu(OP_SUBTRACT_WITH_BORROW, 8'h05, 8'h05, 8'h00, 1'b0, 1'b0);
	endtask
	task automatic t_add;
		alu(OP_ADD, 8'hff, 8'h01, 8'h00, 1'b1, 1'b1);
		alu(OP_ADD_WITH_CARRY, 8'h00, 8'h00, 8'h01, 1'b0, 1'b0);
		alu(OP_ADD, 8'h01, 8'hff, 8'h00, 1'b1, 1'b1);
		alu(OP_ADD_WITH_CARRY, 8'hff, 8'h00, 8'h00, 1'b1, 1'b1);
	endtask
	task automatic t_cmp;
		alu(OP_COMPARE, 8'h34, 8'h34, 8'h00, 1'b0, 1'b1);
		alu(OP_CHAINED_COMPARE, 8'h12, 8'h12, 8'h00, 1'b0, 1'b1);
		alu(OP_COMPARE, 8'h35, 8'h34, 8'h00, 1'b0, 1'b0);
		alu(OP_CHAINED_COMPARE, 8'h12, 8'h12, 8'h00, 1'b0, 1'b0);
		alu(OP_COMPARE, 8'h34, 8'h34, 8'h00, 1'b0, 1'b1);
		alu(OP_CHAINED_COMPARE, 8'h12, 8'h13, 8'h00, 1'b1, 1'b0);
		alu(OP_TEST, 8'h0f, 8'h01, 8'h00, 1'b1, 1'b0);
		alu(OP_CHAINED_BIT_TEST, 8'h00, 8'hff, 8'h00, 1'b1, 1'b0);
		alu(OP_TEST, 8'h0f, 8'hf0, 8'h00, 1'b0, 1'b1);
		alu(OP_CHAINED_BIT_TEST, 8'h03, 8'h01, 8'h00, 1'b1, 1'b0);
	endtask
	// watched alongside the request: write and done each stand for one cycle only
	task automatic t_timing;
		fork
			i_seq.issue(OP_SUBTRACT_WITH_BORROW, 8'h09, 8'h02, STK_NONE, 12'h000);
			begin
				repeat (2) @(posedge I_CLK_SYS);
				#1;
				chk("write", 12'h001, {11'h000, o_write_result});
				chk("done early", 12'h000, {11'h000, o_done});
				@(posedge I_CLK_SYS);
				#1;
				chk("done", 12'h001, {11'h000, o_done});
				chk("write once", 12'h000, {11'h000, o_write_result});
				@(posedge I_CLK_SYS);
				#1;
				chk("done late", 12'h000, {11'h000, o_done});
			end
		join
		fork
			i_seq.issue(OP_CHAINED_COMPARE, 8'h07, 8'h07, STK_NONE, 12'h000);
			begin
				repeat (2) @(posedge I_CLK_SYS);
				#1;
				chk("compare write", 12'h000, {11'h000, o_write_result});
				chk("compare done early", 12'h000, {11'h000, o_done});
				@(posedge I_CLK_SYS);
				#1;
				chk("compare done", 12'h001, {11'h000, o_done});
			end
		join
	endtask
	task automatic t_stack;
		for (int i = 0; i < 30; i++)
			stack_op(STK_CALL, 12'h100 + 12'(i));
		chk("depth", 12'd30, {7'h00, o_stack_depth});
		for (int k = 29; k >= 0; k--)
		begin
			stack_op(STK_RETURN, 12'h000);
			chk("top", (k == 0) ? 12'h000 : 12'h0ff + 12'(k), o_return_addr);
		end
		stack_op(STK_RETURN, 12'h000);
		chk("underflow", 12'h001, {11'h000, o_internal_reset});
		repeat (8) @(posedge I_CLK_SYS);
		#1;
		chk("released", 12'h000, {11'h000, o_internal_reset});
		for (int i = 0; i < 30; i++)
			stack_op(STK_CALL, 12'h200 + 12'(i));
		alu(OP_ADD, 8'hff, 8'h01, 8'h00, 1'b1, 1'b1);
		stack_op(STK_CALL, 12'h2ff);
		chk("overflow", 12'h001, {11'h000, o_internal_reset});
		chk("cleared depth", 12'h000, {7'h00, o_stack_depth});
		chk("cleared carry", 12'h000, {11'h000, o_carry});
	endtask
	// ======================================
	// main sequence and hang guard
	always @(posedge I_CLK_SYS)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			bad_count++;
			close_out();
		end
	end
	initial
	begin
		repeat (16) @(posedge I_CLK_SYS);
		#1;
		I_RESET_N = 1'b1;
		t_sub();
		t_add();
		t_cmp();
		t_timing();
		t_stack();
		close_out();
	end
endmodule
`default_nettype wire
